//--- hw/irq_pkg.sv
// constants, register map and state codes of the interrupt flag and enable unit
// assumes one 100 MHz clock; four clocks form one instruction cycle (phases q1 to q4)
package irq_pkg;

  // timing
  localparam int unsigned CLK_MHZ     = 100;
  localparam int unsigned TCY_CLKS    = 4;                  // q1..q4 phases per cycle
  localparam int unsigned TCY_NS      = TCY_CLKS * 1000 / CLK_MHZ;
  localparam logic [1:0]  LATENCY_TCY = 2'h3;               // instruction cycles to vector
  localparam int unsigned LAT_CLKS    = 32'(LATENCY_TCY) * TCY_CLKS;
  localparam logic [1:0]  Q1_PHASE    = 2'h0;
  localparam logic [1:0]  QCNT_LAST   = 2'(TCY_CLKS - 1);

  // register indices; byte address is four times the index
  localparam int unsigned ADDR_W          = 12;
  localparam logic [7:0]  IDX_IRQ_CONTROL = 8'h0b;
  localparam logic [7:0]  IDX_PFLAGS_1    = 8'h0c;
  localparam logic [7:0]  IDX_PFLAGS_2    = 8'h0d;
  localparam logic [7:0]  IDX_PENABLE_1   = 8'h8c;
  localparam logic [7:0]  IDX_PENABLE_2   = 8'h8d;
  localparam logic [7:0]  IDX_EDGE_OPT    = 8'h81;
  localparam logic [7:0]  IDX_PIN_CHG_EN  = 8'h96;
  localparam logic [7:0]  IDX_CORE_STAT   = 8'h97;

  // irq_control fields
  localparam int unsigned GIE_BIT   = 7;
  localparam int unsigned PERIPH_IRQ_ENABLE_BIT  = 6;
  localparam int unsigned TIMER_ZERO_IRQ_ENABLE_BIT  = 5;
  localparam int unsigned EXT_PIN_IRQ_ENABLE_BIT  = 4;
  localparam int unsigned PORT_CHANGE_IRQ_ENABLE_BIT  = 3;
  localparam int unsigned TIMER_ZERO_IRQ_FLAG_BIT  = 2;
  localparam int unsigned EXT_PIN_IRQ_FLAG_BIT  = 1;
  localparam int unsigned PORT_CHANGE_IRQ_FLAG_BIT  = 0;
  localparam int unsigned EDGE_BIT  = 6;                    // edge select in option reg

  // reset values and masks
  localparam logic [7:0]  REG_RST     = 8'h00;
  localparam logic [7:0]  PF2_MASK    = 8'hf5;              // bits 3 and 1 unimplemented
  localparam logic [7:0]  T0_TOP      = 8'hff;
  localparam logic [7:0]  T0_ZERO     = 8'h00;
  localparam logic [12:0] IRQ_VECTOR  = 13'h0004;
  localparam logic [12:0] PC_RST      = 13'h0000;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_WAIT = 2'b10
  } take_state_t;

endpackage

//--- hw/irq_src_if.sv
// event pulse and change level from the pin-side detectors to the flag logic
// assumes all three modules share one clock
`timescale 1ns/1ps
interface irq_src_if;
  logic ext_evt;   // one-cycle pulse, valid pin edge
  logic port_evt;  // level while an enabled port pin differs from the last read

  modport ext_src  (output ext_evt);
  modport port_src (output port_evt);
  modport sink     (input ext_evt, input port_evt);
endinterface

//--- hw/ext_edge_detect.sv
// edge detector for the external interrupt pin
// assumes the pin is synchronous to CLK
`timescale 1ns/1ps
module ext_edge_detect
  import irq_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic pin,
  input  wire logic edge_sel,
  input  wire logic seg_active,
  irq_src_if.ext_src src
);

  logic pin_q;

  // last pin level for edge compare
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_q <= 1'b0;
    end else begin
      pin_q <= pin;
    end
  end

  // rising when selected, else falling; display drive masks it
  assign src.ext_evt = !seg_active &&
                       (edge_sel ? (pin && !pin_q) : (!pin && pin_q));

  chk_edge_polarity: assert property (@(posedge clk) disable iff (rst)
    (!seg_active && edge_sel && $rose(pin)) |-> src.ext_evt)
    else $error("rising edge not flagged");

  chk_seg_blocks: assert property (@(posedge clk) disable iff (rst)
    seg_active |-> !src.ext_evt)
    else $error("edge passed while display drives pin");

endmodule

//--- hw/port_change_detect.sv
// mismatch detector for the port change interrupt
// assumes the core pulses port_read when it reads the port
`timescale 1ns/1ps
module port_change_detect
  import irq_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [7:0] pins,
  input  wire logic [7:0] change_en,
  input  wire logic       port_read,
  irq_src_if.port_src     src
);

  logic [7:0] snap_q;

  // snapshot taken on each read; a change in that very cycle still raises port_evt for that cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      snap_q <= REG_RST;
    end else if (port_read) begin
      snap_q <= pins;
    end
  end

  // only pins enabled one by one take part
  assign src.port_evt = |((pins ^ snap_q) & change_en);

  chk_masked_pins: assert property (@(posedge clk) disable iff (rst)
    (change_en == 8'h00) |-> !src.port_evt)
    else $error("port change raised with no pin enabled");

endmodule

//--- hw/irq_flag_unit.sv
// interrupt flag, enable and dispatch unit with an APB register port
// assumes the core pulses RETURN_FROM_IRQ on return and obeys IRQ_TAKE
//
// Design decision made here: the APB register port.
`timescale 1ns/1ps
module irq_flag_unit
  import irq_pkg::*;
(
  input  wire logic              CLK,
  input  wire logic              RST,
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [ADDR_W-1:0] PADDR,
  input  wire logic [31:0]       PWDATA,
  output logic      [31:0]       PRDATA,
  output logic                   PREADY,
  output logic                   PSLVERR,
  input  wire logic              EXT_PIN,
  input  wire logic              SEG_ACTIVE,
  input  wire logic [7:0]        PORT_PINS,
  input  wire logic              PORT_READ,
  input  wire logic [7:0]        TIMER_ZERO_COUNT,
  input  wire logic [7:0]        PERIPH1_EVT,
  input  wire logic [7:0]        PERIPH2_EVT,
  input  wire logic              RETURN_FROM_IRQ,
  input  wire logic              SLEEPING,
  output logic                   IRQ_REQ,
  output logic                   IRQ_TAKE,
  output logic                   STACK_PUSH,
  output logic      [12:0]       VECTOR_PC,
  output logic                   WAKE_UP
);

  //////////////////////////////////////////////////////////////////////////////
  // registers and wires

  logic [7:0]  ctrl_q, ctrl_d;
  logic [7:0]  pf1_q, pf2_q, pe1_q, pe2_q;
  logic [7:0]  opt_q, ioc_q;
  logic [7:0]  t0_q;
  logic [1:0]  qcnt_q;
  logic [1:0]  lat_q;
  take_state_t st_q;
  logic        pready_q, perr_q;
  logic [31:0] prdata_q;
  logic        req_q, take_q, wake_q;
  logic [12:0] vec_q;

  logic        access, wr, rd_hit;
  logic [7:0]  idx, rd_data;
  logic        q1, t0_roll, core_pend, periph_pend, any_pend, req_w, take_w;
  logic        wake_w;

  irq_src_if src ();

  ext_edge_detect u_ext (
    .clk        (CLK),
    .rst        (RST),
    .pin        (EXT_PIN),
    .edge_sel   (opt_q[EDGE_BIT]),
    .seg_active (SEG_ACTIVE),
    .src        (src.ext_src)
  );

  port_change_detect u_port (
    .clk       (CLK),
    .rst       (RST),
    .pins      (PORT_PINS),
    .change_en (ioc_q),
    .port_read (PORT_READ),
    .src       (src.port_src)
  );

  //////////////////////////////////////////////////////////////////////////////
  // apb slave: one wait state, answer registered

  assign access = PSEL && PENABLE;
  assign wr     = access && pready_q && PWRITE;
  assign idx    = PADDR[9:2];

  // read mux; misaligned or unknown index answers with an error
  always_comb begin
    rd_hit  = (PADDR[1:0] == 2'h0) && (PADDR[ADDR_W-1:10] == 2'h0);
    rd_data = REG_RST;
    case (idx)
      IDX_IRQ_CONTROL: rd_data = ctrl_q;
      IDX_PFLAGS_1:    rd_data = pf1_q;
      IDX_PFLAGS_2:    rd_data = pf2_q & PF2_MASK;
      IDX_PENABLE_1:   rd_data = pe1_q;
      IDX_PENABLE_2:   rd_data = pe2_q & PF2_MASK;
      IDX_EDGE_OPT:    rd_data = opt_q;
      IDX_PIN_CHG_EN:  rd_data = ioc_q;
      IDX_CORE_STAT:   rd_data = {4'h0, wake_q, req_q, lat_q};
      default:         rd_hit  = 1'b0;
    endcase
  end

  // pready rises in the second access cycle, then drops
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      pready_q <= 1'b0;
      perr_q   <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= access && !pready_q;
      perr_q   <= access && !pready_q && !rd_hit;
      prdata_q <= (access && !pready_q && !PWRITE) ? {24'h00_0000, rd_data} : 32'h0000_0000;
    end
  end

  assign PREADY  = pready_q;
  assign PSLVERR = perr_q;
  assign PRDATA  = prdata_q;

  //////////////////////////////////////////////////////////////////////////////
  // plain software registers

  // enables, edge select and per-pin change enables
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      pe1_q <= REG_RST;
      pe2_q <= REG_RST;
      opt_q <= REG_RST;
      ioc_q <= REG_RST;
    end else if (wr && rd_hit) begin
      if (idx == IDX_PENABLE_1) begin
        pe1_q <= PWDATA[7:0];
      end
      if (idx == IDX_PENABLE_2) begin
        pe2_q <= PWDATA[7:0] & PF2_MASK;
      end
      if (idx == IDX_EDGE_OPT) begin
        opt_q <= PWDATA[7:0] & (8'h01 << EDGE_BIT);
      end
      if (idx == IDX_PIN_CHG_EN) begin
        ioc_q <= PWDATA[7:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // event sources

  // timer zero roll-over seen as ff followed by 00
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      t0_q <= REG_RST;
    end else begin
      t0_q <= TIMER_ZERO_COUNT;
    end
  end

  assign t0_roll = (t0_q == T0_TOP) && (TIMER_ZERO_COUNT == T0_ZERO);

  //////////////////////////////////////////////////////////////////////////////
  // control register: software write first, hardware sets last so a set wins

  always_comb begin
    ctrl_d = ctrl_q;
    if (wr && rd_hit && idx == IDX_IRQ_CONTROL) begin
      ctrl_d = PWDATA[7:0];
    end
    if (take_w) begin
      ctrl_d[GIE_BIT] = 1'b0;
    end
    if (RETURN_FROM_IRQ) begin
      ctrl_d[GIE_BIT] = 1'b1;
    end
    if (src.ext_evt) begin
      ctrl_d[EXT_PIN_IRQ_FLAG_BIT] = 1'b1;
    end
    if (src.port_evt) begin
      ctrl_d[PORT_CHANGE_IRQ_FLAG_BIT] = 1'b1;
    end
    if (t0_roll) begin
      ctrl_d[TIMER_ZERO_IRQ_FLAG_BIT] = 1'b1;
    end
  end

  // reset leaves interrupts off until software turns them on
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ctrl_q <= REG_RST;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // peripheral flags; events set regardless of enables
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      pf1_q <= REG_RST;
      pf2_q <= REG_RST;
    end else begin
      pf1_q <= ((wr && rd_hit && idx == IDX_PFLAGS_1) ? PWDATA[7:0] : pf1_q)
               | PERIPH1_EVT;
      pf2_q <= (((wr && rd_hit && idx == IDX_PFLAGS_2) ? PWDATA[7:0] : pf2_q)
               | PERIPH2_EVT) & PF2_MASK;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // request qualification

  // flag bits 2..0 line up with enable bits 5..3
  assign core_pend   = |(ctrl_q[TIMER_ZERO_IRQ_FLAG_BIT:PORT_CHANGE_IRQ_FLAG_BIT] & ctrl_q[TIMER_ZERO_IRQ_ENABLE_BIT:PORT_CHANGE_IRQ_ENABLE_BIT]);
  assign periph_pend = |((pf1_q & pe1_q) | (pf2_q & pe2_q));
  assign any_pend    = core_pend || (ctrl_q[PERIPH_IRQ_ENABLE_BIT] && periph_pend);
  // level stays until software clears the flags or the global enable drops
  assign req_w       = ctrl_q[GIE_BIT] && any_pend;
  // wake ignores both the global and the peripheral irq enable bits, not the per-source enables
  assign wake_w      = SLEEPING && (core_pend || periph_pend);

  //////////////////////////////////////////////////////////////////////////////
  // instruction cycle phases

  // free-running q1..q4 divider; q1 is a one-clock enable
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      qcnt_q <= Q1_PHASE;
    end else begin
      qcnt_q <= (qcnt_q == QCNT_LAST) ? Q1_PHASE : qcnt_q + 2'h1;
    end
  end

  assign q1 = (qcnt_q == Q1_PHASE);

  //////////////////////////////////////////////////////////////////////////////
  // dispatch: sample at q1, vector three instruction cycles later

  // counting q1 edges keeps latency equal for one- and two-cycle instructions
  assign take_w = (st_q == ST_WAIT) && q1 && ctrl_q[GIE_BIT]
                  && (lat_q == LATENCY_TCY);

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      st_q  <= ST_IDLE;
      lat_q <= 2'h0;
    end else if (q1) begin
      case (st_q)
        ST_IDLE: begin
          if (req_w) begin
            st_q  <= ST_WAIT;
            lat_q <= 2'h1;
          end
        end
        ST_WAIT: begin
          if (!ctrl_q[GIE_BIT] || take_w) begin
            st_q  <= ST_IDLE;
            lat_q <= 2'h0;
          end else begin
            lat_q <= lat_q + 2'h1;
          end
        end
        default: begin
          st_q  <= ST_IDLE;
          lat_q <= 2'h0;
        end
      endcase
    end
  end

  // core strobes; only the return address is pushed, no other context
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      take_q <= 1'b0;
      vec_q  <= PC_RST;
      req_q  <= 1'b0;
      wake_q <= 1'b0;
    end else begin
      take_q <= take_w;
      req_q  <= req_w;
      wake_q <= wake_w;
      if (take_w) begin
        vec_q <= IRQ_VECTOR;
      end
    end
  end

  assign IRQ_REQ    = req_q;
  assign IRQ_TAKE   = take_q;
  assign STACK_PUSH = take_q;
  assign VECTOR_PC  = vec_q;
  assign WAKE_UP    = wake_q;

  //////////////////////////////////////////////////////////////////////////////
  // checks

  chk_reset_gie_off: assert property (@(posedge CLK)
    $fell(RST) |-> !ctrl_q[GIE_BIT])
    else $error("global enable set after reset");

  chk_take_needs_gie: assert property (@(posedge CLK) disable iff (RST)
    !ctrl_q[GIE_BIT] |-> !take_w)
    else $error("take while global enable clear");

  chk_take_entry: assert property (@(posedge CLK) disable iff (RST)
    (take_w && !RETURN_FROM_IRQ) |=> !ctrl_q[GIE_BIT] && IRQ_TAKE && STACK_PUSH
                                     && VECTOR_PC == IRQ_VECTOR)
    else $error("interrupt entry incomplete");

  chk_return_sets: assert property (@(posedge CLK) disable iff (RST)
    RETURN_FROM_IRQ |=> ctrl_q[GIE_BIT])
    else $error("return did not re-enable");

  chk_take_latency: assert property (@(posedge CLK) disable iff (RST)
    (st_q == ST_IDLE && q1 && req_w) ##1 ctrl_q[GIE_BIT] [*8] ##1 ctrl_q[GIE_BIT] [*4]
      |-> take_w)
    else $error("take not at three instruction cycles");

  chk_disable_drops: assert property (@(posedge CLK) disable iff (RST)
    (st_q == ST_WAIT && q1 && !ctrl_q[GIE_BIT]) |=> st_q == ST_IDLE ##1 !IRQ_TAKE)
    else $error("take kept after global disable");

  chk_flag_set_wins: assert property (@(posedge CLK) disable iff (RST)
    src.ext_evt |=> ctrl_q[EXT_PIN_IRQ_FLAG_BIT])
    else $error("external flag lost");

  chk_t0_roll: assert property (@(posedge CLK) disable iff (RST)
    t0_roll |=> ctrl_q[TIMER_ZERO_IRQ_FLAG_BIT])
    else $error("timer roll-over not flagged");

  chk_pf2_reserved: assert property (@(posedge CLK) disable iff (RST)
    ((pf2_q | pe2_q) & ~PF2_MASK) == 8'h00)
    else $error("unimplemented bit set");

  chk_req_level: assert property (@(posedge CLK) disable iff (RST)
    IRQ_REQ == $past(ctrl_q[GIE_BIT] && any_pend))
    else $error("request level mismatch");

  chk_wake_any_gie: assert property (@(posedge CLK) disable iff (RST)
    (SLEEPING && ctrl_q[EXT_PIN_IRQ_FLAG_BIT] && ctrl_q[EXT_PIN_IRQ_ENABLE_BIT]) |=> WAKE_UP)
    else $error("enabled source did not wake");

  cov_take: cover property (@(posedge CLK) disable iff (RST) IRQ_TAKE);
  cov_wake_no_gie: cover property (@(posedge CLK) disable iff (RST)
    WAKE_UP && !ctrl_q[GIE_BIT]);
  cov_drop: cover property (@(posedge CLK) disable iff (RST)
    st_q == ST_WAIT && q1 && !ctrl_q[GIE_BIT]);

endmodule

//--- testbench/irq_core_model.sv
// behavioural core: answers each take with a return after a routine delay
// assumes it shares the clock and reset of the unit under test
`timescale 1ns/1ps
module irq_core_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       irq_take,
  input  wire logic       stack_push,
  input  wire logic       ret_en,
  input  wire logic [3:0] ret_delay,
  output logic            return_from_irq,
  output logic      [3:0] depth_q
);
  logic [4:0] wait_q;

  ////////////////////////////////////////////////////////////////////////////
  // stack depth; only the return address is ever pushed
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      depth_q <= 4'h0;
    end else if (stack_push) begin
      depth_q <= depth_q + 4'h1;
    end else if (return_from_irq) begin
      depth_q <= depth_q - 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // routine length chosen by the bench; return re-arms the enable
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wait_q          <= 5'h00;
      return_from_irq <= 1'b0;
    end else begin
      return_from_irq <= 1'b0;
      if (irq_take) begin
        wait_q <= {1'b0, ret_delay} + 5'h01;
      end else if (wait_q == 5'h01) begin
        wait_q          <= 5'h00;
        return_from_irq <= ret_en;            // a stalled routine never returns
      end else if (wait_q != 5'h00) begin
        wait_q <= wait_q - 5'h01;
      end
    end
  end
endmodule

//--- testbench/interrupt_flag_enable_unit_tb_top.sv
// self-checking bench for the interrupt flag and enable unit
// assumes the unit answers apb with one wait state and the core model beside it
`timescale 1ns/1ps
module interrupt_flag_enable_unit_tb_top;
  import irq_pkg::*;
  typedef struct packed {logic rd; logic [7:0] d; logic e;} note_t;
  logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr, irq_req, irq_take, stack_push, wake_up, ret;
  logic        ext_pin = 1'b0, seg_on = 1'b0, port_rd = 1'b0, sleeping = 1'b0;
  logic        ret_en = 1'b0, seen;
  logic [7:0]  pins = 8'h00, t0 = 8'h00, p1 = 8'h00, p2 = 8'h00, v1, v2;
  logic [3:0]  dly = 4'h8, depth;
  logic [12:0] vec;
  logic [7:0]  regs_a [5] = '{IDX_IRQ_CONTROL, IDX_PFLAGS_1, IDX_PFLAGS_2, IDX_PENABLE_1,
                              IDX_PENABLE_2};
  int          failures = 0, total_checks = 0, cycles = 0, n;
  int          seed = 32'h1d1ad6ce;
  note_t       notes[$];
  note_t       nt;

  always #5 clk = ~clk;

  irq_flag_unit dut (.CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .EXT_PIN(ext_pin), .SEG_ACTIVE(seg_on), .PORT_PINS(pins), .PORT_READ(port_rd),
    .TIMER_ZERO_COUNT(t0), .PERIPH1_EVT(p1), .PERIPH2_EVT(p2), .RETURN_FROM_IRQ(ret),
    .SLEEPING(sleeping), .IRQ_REQ(irq_req), .IRQ_TAKE(irq_take), .STACK_PUSH(stack_push),
    .VECTOR_PC(vec), .WAKE_UP(wake_up));

  irq_core_model core (.clk(clk), .rst(rst), .irq_take(irq_take), .stack_push(stack_push),
    .ret_en(ret_en), .ret_delay(dly), .return_from_irq(ret), .depth_q(depth));

  ////////////////////////////////////////////////////////////////////////////
  // reporting and comparison
  task automatic end_of_test();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // hang guard, well above the few hundred cycles the sequence needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      end_of_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb master; the expected answer is noted before the request goes out
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                     input logic [7:0] exp, input logic err);
    notes.push_back('{~wr, exp, err});
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {2'h0, idx, 2'h0};
    pwdata  <= {24'($random(seed)), wd};    // upper bits must be ignored
    @(posedge clk);
    penable <= 1'b1;
    // access phase lasts until pready is seen high at a rising edge
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    apb(1'b1, i, d, 8'h00, 1'b0);
  endtask

  task automatic rd(input logic [7:0] i, input logic [7:0] d);
    apb(1'b0, i, 8'h00, d, 1'b0);
  endtask

  // watcher: each finished transfer against the oldest note
  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1) begin
      nt = notes.pop_front();
      chk("slave error", 32'(nt.e), 32'(pslverr));
      if (nt.rd) chk("read data", {24'h0, nt.d}, prdata);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // take watching, sampled just after each edge so flops have settled
  task automatic wait_take(input string what, input int lo, input int hi);
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (irq_take !== 1'b1 && n < 60);
    chk(what, 32'h1, 32'(n >= lo && n <= hi));
    chk("push with take", 32'h1, 32'(stack_push));
    chk("vector", 32'(IRQ_VECTOR), 32'(vec));
  endtask

  task automatic no_take(input int k);
    seen = 1'b0;
    repeat (k) begin
      @(posedge clk);
      #1;
      if (irq_take === 1'b1) seen = 1'b1;
    end
    chk("unexpected take", 32'h0, 32'(seen));
  endtask

  task automatic drive_pin(input logic v);
    @(posedge clk);
    ext_pin <= v;
    repeat (2) @(posedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    foreach (regs_a[i]) rd(regs_a[i], REG_RST);
    // unimplemented bits of the second pair must read zero
    for (int i = 1; i < 5; i++) begin
      wr(regs_a[i], 8'hff);
      rd(regs_a[i], (i % 2) ? 8'hff : PF2_MASK);
      wr(regs_a[i], 8'h00);
    end
    apb(1'b1, 8'h8b, 8'hff, 8'h00, 1'b1);
    apb(1'b0, 8'h8b, 8'h00, 8'h00, 1'b1);
    // both edge selects: wrong edge ignored, right edge sets the flag
    for (int s = 0; s < 2; s++) begin
      wr(IDX_EDGE_OPT, 8'(s << EDGE_BIT));
      drive_pin(s[0]);
      wr(IDX_IRQ_CONTROL, 8'h00);
      drive_pin(~s[0]);
      rd(IDX_IRQ_CONTROL, 8'h00);
      drive_pin(s[0]);
      rd(IDX_IRQ_CONTROL, 8'h02);
      wr(IDX_IRQ_CONTROL, 8'h00);
    end
    // display drive on the pin masks its edges
    seg_on <= 1'b1;
    drive_pin(1'b0);
    drive_pin(1'b1);
    rd(IDX_IRQ_CONTROL, 8'h00);
    seg_on <= 1'b0;
    // timer roll-over and port change, all irq_control enables off
    t0 <= T0_TOP;
    @(posedge clk);
    t0 <= T0_ZERO;
    rd(IDX_IRQ_CONTROL, 8'h04);
    v1 = 8'($random(seed)) | 8'h01;
    wr(IDX_PIN_CHG_EN, v1);
    pins <= ~v1;
    rd(IDX_IRQ_CONTROL, 8'h04);
    pins <= v1;
    rd(IDX_IRQ_CONTROL, 8'h05);
    @(posedge clk);
    port_rd <= 1'b1;
    @(posedge clk);
    port_rd <= 1'b0;
    wr(IDX_IRQ_CONTROL, 8'h00);
    rd(IDX_IRQ_CONTROL, 8'h00);
    // peripheral events land in their flag bits with enables off
    v1 = 8'($random(seed)) | 8'h01;
    v2 = 8'($random(seed));
    @(posedge clk);
    p1 <= v1;
    p2 <= v2;
    @(posedge clk);
    p1 <= 8'h00;
    p2 <= 8'h00;
    rd(IDX_PFLAGS_1, v1);
    rd(IDX_PFLAGS_2, v2 & PF2_MASK);
    wr(IDX_PENABLE_1, v1);
    wr(IDX_IRQ_CONTROL, 8'h80);
    repeat (3) @(posedge clk);
    #1;
    chk("request without periph_irq_enable", 32'h0, 32'(irq_req));
    // core returns slowly; flags left set so the request repeats
    dly    <= 4'($random(seed)) | 4'h8;
    ret_en <= 1'b1;
    wr(IDX_IRQ_CONTROL, 8'hc0);
    wait_take("first take latency", LAT_CLKS + 1, LAT_CLKS + TCY_CLKS);
    // the model counts the push at the edge that ends the take pulse
    @(posedge clk);
    #1;
    chk("stack depth", 32'h1, 32'(depth));
    wait_take("repeat take", 14, 36);
    wr(IDX_PFLAGS_1, 8'h00);
    no_take(40);
    rd(IDX_IRQ_CONTROL, 8'hc0);
    chk("stack after returns", 32'h0, 32'(depth));
    chk("request after clear", 32'h0, 32'(irq_req));
    // enable dropped during the wait: take cancelled, flags kept
    ret_en <= 1'b0;
    wr(IDX_PFLAGS_1, v1);
    wr(IDX_IRQ_CONTROL, 8'h40);
    no_take(30);
    wr(IDX_IRQ_CONTROL, 8'hc0);
    wait_take("retaken after enable", LAT_CLKS + 1, LAT_CLKS + TCY_CLKS);
    rd(IDX_IRQ_CONTROL, 8'h40);
    wr(IDX_PFLAGS_1, 8'h00);
    // sleep: enabled pin edge wakes with the global enable off
    sleeping <= 1'b1;
    wr(IDX_IRQ_CONTROL, 8'h10);
    drive_pin(1'b0);
    drive_pin(1'b1);
    // wake flop loads at the edge drive_pin returns on; look once it has settled
    #1;
    chk("wake on edge", 32'h1, 32'(wake_up));
    chk("no request asleep", 32'h0, 32'(irq_req));
    rd(IDX_CORE_STAT, 8'h08);
    wr(IDX_IRQ_CONTROL, 8'h82);
    repeat (3) @(posedge clk);
    #1;
    chk("wake without enable", 32'h0, 32'(wake_up));
    chk("request without enable", 32'h0, 32'(irq_req));
    end_of_test();
  end
endmodule
